// >>> design/pbmc_crc8.sv
// pbmc_crc8: serial 8-bit check code over control word bits
`timescale 1ns/1ps
`default_nettype none
module pbmc_crc8 import pbmc_pkg::*; (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	// bit stream
	input  wire logic       clear,
	input  wire logic       en,
	input  wire logic       din,
	// residue
	output logic      [7:0] crc
);
	wire       fb       = crc[7] ^ din;
	wire [7:0] next_crc = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) crc <= 8'h00;
		else if (clear) crc <= 8'h00;
		else if (en) crc <= next_crc;
	end
endmodule : pbmc_crc8
`default_nettype wire

// >>> design/pbmc_port.sv
// pbmc_port: packet bus port unit with its software register block
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pbmc_port import pbmc_pkg::*; (
	// clock and reset
	input  wire logic           ref_clk,
	input  wire logic           resetn,
	// software register bus
	input  wire pbmc_axil_req_t axil_req,
	output var  pbmc_axil_rsp_t axil_rsp,
	// lines to the bus master controller
	input  wire logic           poll,
	output logic                inhibit,
	output logic                ack,
	output logic                irq,
	// shared serial bus
	input  wire logic           frame_sync,
	input  wire pbmc_bit_t      rx_bit,
	output var  pbmc_bit_t      tx_bit
);
	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	logic            en, role_tx, cls, busy, irq_req;
	logic            rx_full, cw_ok, cw_bad, blk_fail, tx_done;
	logic            poll_q, taking, poll_lost, sending;
	logic            tx_v, tx_d;
	logic            bvalid, rvalid;
	logic      [1:0] bresp, rresp;
	logic     [31:0] rdata, word_sh;
	logic      [7:0] cw_cnt, crc_q;
	logic     [11:0] bcnt, tcnt;
	logic      [6:0] acc;
	logic    [183:0] cw_sh;
	pbmc_ctrl_word_t cw;
	pbmc_slot_t      slot;
	logic            slot_last;
	logic     [31:0] mem [BUF_WORDS];

	pbmc_slot_timer u_timer (
		.ref_clk    (ref_clk),
		.resetn     (resetn),
		.frame_sync (frame_sync),
		.slot       (slot),
		.slot_last  (slot_last)
	);

	// -------------------------------------------------------------
	// slot and bit decode
	// -------------------------------------------------------------
	wire ctrl_end   = slot_last && slot == SLOT_CTRL;
	wire data_enter = slot_last && slot == SLOT_SYNC2;
	wire data_end   = slot_last && slot == SLOT_DATA;
	wire in_data    = slot == SLOT_DATA;
	wire rx_ok      = en && rx_bit.valid && rx_bit.cls == cls;
	wire cw_take    = rx_ok && slot == SLOT_CTRL && cw_cnt != CW_BITS;
	wire cw_good    = ctrl_end && cw_cnt == CW_BITS && crc_q == 8'h00;
	wire cw_fail    = ctrl_end && cw_cnt != 8'h00 && !cw_good;
	wire dat_take   = taking && in_data && rx_ok && bcnt != BLOCK_BITS;
	wire word_done  = dat_take && bcnt[4:0] == 5'h1f;
	wire blk_good   = data_end && taking && !poll_lost && bcnt != 12'h000;
	wire blk_bad    = data_end && taking && !blk_good;
	wire poll_rise  = poll && !poll_q;
	wire [7:0] rate_sum = {1'b0, acc} + RATE_ADD;
	wire       emit     = rate_sum >= RATE_MOD;
	wire [6:0] next_acc = emit ? 7'(rate_sum - RATE_MOD) : rate_sum[6:0];
	wire tx_go      = sending && in_data && poll && emit && tcnt != BLOCK_BITS;
	wire [31:0] tx_word = mem[tcnt[10:5]];
	wire        tx_bitv = tx_word[5'h1f - tcnt[4:0]];

	pbmc_crc8 u_crc (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.clear   (slot == SLOT_SYNC1),
		.en      (cw_take),
		.din     (rx_bit.data),
		.crc     (crc_q)
	);

	// -------------------------------------------------------------
	// register bus decode
	// -------------------------------------------------------------
	wire [11:0] wa    = axil_req.awaddr;
	wire [11:0] ra    = axil_req.araddr;
	wire        wr_go = axil_req.awvalid && axil_req.wvalid && !bvalid;
	wire        rd_go = axil_req.arvalid && !rvalid;
	wire        w_ctl = wr_go && wa == OFS_CONTROL && axil_req.wstrb[0];
	wire        w_st  = wr_go && wa == OFS_STATUS && axil_req.wstrb[0];
	wire        w_buf = wr_go && wa[11:8] == BUF_PAGE && !word_done;
	wire        w_map = wa < OFS_MAPEND || wa[11:8] == BUF_PAGE;
	wire        r_map = ra < OFS_MAPEND || ra[11:8] == BUF_PAGE;
	wire        w_irq_set = w_ctl && axil_req.wdata[CTL_IRQ];
	wire  [4:0] clr   = w_st ? axil_req.wdata[4:0] : 5'h00;
	wire [31:0] wmask;
	wire [31:0] w_old = mem[wa[7:2]];
	wire [31:0] w_new = (w_old & ~wmask) | (axil_req.wdata & wmask);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wmask[8*gi +: 8] = {8{axil_req.wstrb[gi]}};
		end
	endgenerate

	wire [31:0] r_ctl = {27'h0, busy, irq_req, cls, role_tx, en};
	wire [31:0] r_st  = {22'h0, slot, ack, inhibit, poll, tx_done, blk_fail, cw_bad, cw_ok, rx_full};
	wire [31:0] r_val = ra[11:8] == BUF_PAGE ? mem[ra[7:2]] :
	                    ra == OFS_CONTROL ? r_ctl :
	                    ra == OFS_STATUS  ? r_st :
	                    ra == OFS_FUNC    ? {16'h0, cw.func} :
	                    ra == OFS_IDENT   ? {8'h0, cw.op.hdr, cw.op.src, cw.op.mission} :
	                    ra == OFS_SEQ     ? cw.op.seq :
	                    ra == OFS_START   ? cw.op.start :
	                    ra == OFS_TOTAL   ? cw.op.total :
	                    ra == OFS_COUNT   ? {20'h0, bcnt} : 32'h0;

	assign axil_rsp = '{awready: wr_go, wready: wr_go, bvalid: bvalid, bresp: bresp,
	                    arready: rd_go, rvalid: rvalid, rdata: rdata, rresp: rresp};
	assign inhibit  = busy || rx_full;
	assign irq      = irq_req;
	assign tx_bit   = '{valid: tx_v, cls: cls, data: tx_d};

	// -------------------------------------------------------------
	// register bus responses
	// -------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp  <= w_map ? RESP_OKAY : RESP_SLVERR;
		end else if (axil_req.bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= RESP_OKAY;
		end else if (rd_go) begin
			rvalid <= 1'b1;
			rdata  <= r_val;
			rresp  <= r_map ? RESP_OKAY : RESP_SLVERR;
		end else if (axil_req.rready) begin
			rvalid <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// software control and sticky flags
	// -------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			{en, role_tx, cls, busy} <= 4'h0;
		end else if (w_ctl) begin
			en      <= axil_req.wdata[CTL_EN];
			role_tx <= axil_req.wdata[CTL_TX];
			cls     <= axil_req.wdata[CTL_CLS];
			busy    <= axil_req.wdata[CTL_BUSY];
		end
	end

	// set wins over clear for every flag below
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			{irq_req, rx_full, cw_ok, cw_bad, blk_fail, tx_done} <= 6'h00;
		end else begin
			irq_req  <= w_irq_set || (irq_req && !poll_rise);
			rx_full  <= blk_good || (rx_full && !clr[ST_RXFULL]);
			cw_ok    <= cw_good || (cw_ok && !clr[ST_CWOK]);
			cw_bad   <= cw_fail || (cw_bad && !clr[ST_CWBAD]);
			blk_fail <= blk_bad || (blk_fail && !clr[ST_BLKFAIL]);
			tx_done  <= (data_end && sending) || (tx_done && !clr[ST_TXDONE]);
		end
	end

	// -------------------------------------------------------------
	// control slot receive
	// -------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cw_cnt <= 8'h00;
			cw_sh  <= '0;
			cw     <= '0;
		end else begin
			if (slot == SLOT_SYNC1) cw_cnt <= 8'h00;
			else if (cw_take) cw_cnt <= cw_cnt + 8'h01;
			if (cw_take) cw_sh <= {cw_sh[182:0], rx_bit.data};
			if (cw_good) cw <= pbmc_ctrl_word_t'(cw_sh);
		end
	end

	// -------------------------------------------------------------
	// data slot receive and acknowledge
	// -------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			poll_q    <= 1'b0;
			taking    <= 1'b0;
			poll_lost <= 1'b0;
			bcnt      <= 12'h000;
			word_sh   <= 32'h0;
			ack       <= 1'b0;
		end else begin
			poll_q <= poll;
			if (data_enter) begin
				taking    <= en && !role_tx && poll && !inhibit;
				poll_lost <= 1'b0;
				bcnt      <= 12'h000;
			end else if (data_end) begin
				taking    <= 1'b0;
			end else begin
				if (taking && !poll) poll_lost <= 1'b1;
				if (dat_take) bcnt <= bcnt + 12'h001;
			end
			if (dat_take) word_sh <= {word_sh[30:0], rx_bit.data};
			ack <= blk_good || (ack && poll);
		end
	end

	// buffer: block data has priority, a software write in the same cycle is dropped
	always_ff @(posedge ref_clk) begin
		if (word_done) mem[bcnt[10:5]] <= {word_sh[30:0], rx_bit.data};
		else if (w_buf) mem[wa[7:2]] <= w_new;
	end

	// -------------------------------------------------------------
	// data slot transmit
	// -------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sending <= 1'b0;
			tcnt    <= 12'h000;
			acc     <= 7'h00;
			tx_v    <= 1'b0;
			tx_d    <= 1'b0;
		end else begin
			if (data_enter) sending <= en && role_tx && poll && !inhibit;
			else if (data_end) sending <= 1'b0;
			if (data_enter) tcnt <= 12'h000;
			else if (tx_go) tcnt <= tcnt + 12'h001;
			acc  <= in_data ? next_acc : 7'h00;
			tx_v <= tx_go;
			tx_d <= tx_go && tx_bitv;
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence s_poll_up;
		!poll ##1 poll;
	endsequence
	sequence s_block_ok;
		taking && !poll_lost && bcnt != 12'h000 ##0 data_end;
	endsequence

	property p_tx_polled;
		tx_v |-> $past(poll) && $past(slot) == SLOT_DATA && role_tx;
	endproperty
	a_tx_polled: assert property (p_tx_polled) else $error("bit sent outside polled data slot");
	property p_tx_rate;
		tx_v [*4] |=> !tx_v;
	endproperty
	a_tx_rate: assert property (p_tx_rate) else $error("transmit faster than 100 Mb/s");
	property p_tx_len;
		tx_v |-> $past(tcnt) < BLOCK_BITS;
	endproperty
	a_tx_len: assert property (p_tx_len) else $error("block longer than 2048 bits");
	property p_take_free;
		$rose(taking) |-> $past(poll) && !$past(inhibit);
	endproperty
	a_take_free: assert property (p_take_free) else $error("block taken while inhibited");
	property p_ack_good;
		s_block_ok |=> ack && rx_full;
	endproperty
	a_ack_good: assert property (p_ack_good) else $error("good block not acknowledged");
	property p_ack_only;
		$rose(ack) |-> $past(taking) && !$past(poll_lost) && $past(data_end);
	endproperty
	a_ack_only: assert property (p_ack_only) else $error("acknowledge without good block");
	property p_cw_check;
		$changed(cw) |-> $past(cw_cnt) == CW_BITS && $past(crc_q) == 8'h00;
	endproperty
	a_cw_check: assert property (p_cw_check) else $error("control word kept with bad check");
	property p_irq_clear;
		s_poll_up ##0 !w_irq_set |=> !irq;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("interrupt not dropped after poll");
	property p_inhibit_full;
		blk_good |=> inhibit [*2];
	endproperty
	a_inhibit_full: assert property (p_inhibit_full) else $error("no inhibit after block buffered");
endmodule : pbmc_port
`default_nettype wire

// >>> design/pbmc_slot_timer.sv
// pbmc_slot_timer: local slot sequencer for synch, control, synch, data
`timescale 1ns/1ps
`default_nettype none
module pbmc_slot_timer import pbmc_pkg::*; (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	// frame alignment
	input  wire logic       frame_sync,
	// slot state
	output pbmc_slot_t      slot,
	output logic            slot_last
);
	logic       [11:0] cnt;
	pbmc_slot_t        next_slot;
	wire        [11:0] len = (slot == SLOT_CTRL) ? CTRL_CYC :
	                         (slot == SLOT_DATA) ? DATA_CYC : SYNC_CYC;

	// a frame_sync cuts the running slot, so its last-cycle decode still fires
	assign slot_last = (cnt == len - 12'h001) || frame_sync;

	always_comb begin
		unique case (slot)
			SLOT_SYNC1: next_slot = SLOT_CTRL;
			SLOT_CTRL:  next_slot = SLOT_SYNC2;
			SLOT_SYNC2: next_slot = SLOT_DATA;
			SLOT_DATA:  next_slot = SLOT_SYNC1;
		endcase
	end

	// free running on the local clock, realigned by frame_sync
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			slot <= SLOT_SYNC1;
			cnt  <= 12'h000;
		end else if (frame_sync) begin
			slot <= SLOT_SYNC1;
			cnt  <= 12'h000;
		end else if (slot_last) begin
			slot <= next_slot;
			cnt  <= 12'h000;
		end else begin
			cnt  <= cnt + 12'h001;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	property p_order;
		slot == SLOT_SYNC2 && slot_last && !frame_sync |=> slot == SLOT_DATA && cnt == 12'h000;
	endproperty
	a_order: assert property (p_order) else $error("data slot did not follow synch");
endmodule : pbmc_slot_timer
`default_nettype wire

// >>> pkg/pbmc_pkg.sv
// pbmc_pkg: constants, types and field layouts of the packet bus port unit
`default_nettype none
package pbmc_pkg;
	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int CLK_NS  = 8;
	localparam int CLK_MHZ = 125;
	localparam int BIT_MBPS = 100;
	localparam int SYNC_NS = 4000;
	localparam int CTRL_NS = 1840;
	localparam int DATA_NS = 20480;
	localparam logic [11:0] SYNC_CYC = 12'((SYNC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] CTRL_CYC = 12'((CTRL_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] DATA_CYC = 12'((DATA_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0]  RATE_ADD = 8'(BIT_MBPS);
	localparam logic [7:0]  RATE_MOD = 8'(CLK_MHZ);
	// -------------------------------------------------------------
	// sizes and check code
	// -------------------------------------------------------------
	localparam logic [11:0] BLOCK_BITS = 12'h800;
	localparam logic [7:0]  CW_BITS    = 8'hb8;
	localparam int          BUF_WORDS  = 64;
	localparam logic [7:0]  CRC_POLY   = 8'h07;
	// -------------------------------------------------------------
	// register map and fields
	// -------------------------------------------------------------
	localparam logic [11:0] OFS_CONTROL = 12'h000;
	localparam logic [11:0] OFS_STATUS  = 12'h004;
	localparam logic [11:0] OFS_FUNC    = 12'h008;
	localparam logic [11:0] OFS_IDENT   = 12'h00c;
	localparam logic [11:0] OFS_SEQ     = 12'h010;
	localparam logic [11:0] OFS_START   = 12'h014;
	localparam logic [11:0] OFS_TOTAL   = 12'h018;
	localparam logic [11:0] OFS_COUNT   = 12'h01c;
	localparam logic [11:0] OFS_MAPEND  = 12'h020;
	localparam logic [3:0]  BUF_PAGE    = 4'h1;
	localparam int CTL_EN = 0, CTL_TX = 1, CTL_CLS = 2, CTL_IRQ = 3, CTL_BUSY = 4;
	localparam int ST_RXFULL = 0, ST_CWOK = 1, ST_CWBAD = 2, ST_BLKFAIL = 3, ST_TXDONE = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// -------------------------------------------------------------
	// types
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		SLOT_SYNC1 = 2'h0,
		SLOT_CTRL  = 2'h1,
		SLOT_SYNC2 = 2'h3,
		SLOT_DATA  = 2'h2
	} pbmc_slot_t;
	typedef struct packed {
		logic [7:0]  hdr;
		logic [7:0]  src;
		logic [7:0]  mission;
		logic [31:0] seq;
		logic [31:0] start;
		logic [31:0] total;
	} pbmc_pkt_id_t;
	typedef struct packed {
		logic [15:0]  func;
		pbmc_pkt_id_t op;
		logic [39:0]  aux;
		logic [7:0]   crc;
	} pbmc_ctrl_word_t;
	typedef struct packed {
		logic valid;
		logic cls;
		logic data;
	} pbmc_bit_t;
	typedef struct packed {
		logic        awvalid;
		logic [11:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [11:0] araddr;
		logic        rready;
	} pbmc_axil_req_t;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pbmc_axil_rsp_t;
endpackage : pbmc_pkg
`default_nettype wire

// >>> test/pbmc_bus_model.sv
// pbmc_bus_model: controller and peer port model on the far side of the port unit
`timescale 1ns/1ps
`default_nettype none
module pbmc_bus_model import pbmc_pkg::*; (
	// clock and reset
	input  wire logic      ref_clk,
	input  wire logic      resetn,
	// handshake lines
	output logic           poll,
	input  wire logic      inhibit,
	input  wire logic      ack,
	// shared serial bus
	output logic           frame_sync,
	output pbmc_bit_t      rx_bit,
	input  wire pbmc_bit_t tx_bit
);
	// -------------------------------------------------------------
	// frame position and stimulus set by the bench
	// -------------------------------------------------------------
	localparam int LAST = 2 * int'(SYNC_CYC) + int'(CTRL_CYC) + int'(DATA_CYC) - 1;
	localparam int CW0  = 510;
	localparam int DT0  = 1300;
	logic [11:0]  pcnt;
	logic [183:0] cw;
	logic [63:0]  blk;
	logic [63:0]  txw;
	logic         cw_go;
	logic         blk_go;
	logic         abort;
	logic         junk;
	logic         got_ack;
	logic         fail;
	int           nbits;
	int           ntx;
	int           k;
	int           c;
	assign k = int'(pcnt) - DT0;
	assign c = int'(pcnt) - CW0;
	// -------------------------------------------------------------
	// slot clock, bit drive, poll and acknowledge
	// -------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pcnt <= 12'h000;
			frame_sync <= 1'b0;
			poll <= 1'b0;
			rx_bit <= '0;
			junk <= 1'b0;
			got_ack <= 1'b0;
			fail <= 1'b0;
			ntx <= 0;
			txw <= '0;
		end else begin
			pcnt <= (pcnt == 12'(LAST)) ? 12'h000 : pcnt + 12'h001;
			frame_sync <= (pcnt == 12'(LAST - 1));
			junk <= ~junk;
			if (blk_go && k >= 0 && k < 2 * nbits) rx_bit <= '{1'b1, pcnt[0], pcnt[0] ? junk : blk[63 - k / 2]};
			else if (cw_go && c >= 0 && c < 184) rx_bit <= '{1'b1, 1'b0, cw[183 - c]};
			else rx_bit <= '{valid: 1'b0, cls: junk, data: ~junk}; // idle toggles, no stale bit looks valid
			if (!poll && blk_go && pcnt == 12'h3e8 && !inhibit) begin
				poll <= 1'b1;
				got_ack <= 1'b0;
				fail <= 1'b0;
			end else if (poll && ack) begin
				got_ack <= 1'b1;
				poll <= 1'b0;
			end else if (poll && pcnt == 12'h12c) begin
				poll <= 1'b0;
				fail <= 1'b1;
			end else if (poll && abort && pcnt == 12'h7d0) begin
				poll <= 1'b0;
			end
			if (tx_bit.valid && tx_bit.cls) begin
				ntx <= ntx + 1;
				if (ntx < 64) txw <= {txw[62:0], tx_bit.data};
			end
		end
	end
endmodule : pbmc_bus_model
`default_nettype wire

// >>> test/pbmc_port_tb.sv
// pbmc_port_tb: register-level bench of the packet bus port unit
`timescale 1ns/1ps
`default_nettype none
module pbmc_port_tb import pbmc_pkg::*;;
	logic           ref_clk;
	logic           resetn;
	logic           poll;
	logic           frame_sync;
	logic           inhibit;
	logic           ack;
	logic           irq;
	pbmc_bit_t      rx_bit;
	pbmc_bit_t      tx_bit;
	pbmc_axil_req_t rq;
	pbmc_axil_rsp_t rs;
	int             mismatches;
	int             n_tests;
	int             n0;
	logic [31:0]    d;
	logic [1:0]     r;
	logic [175:0]   body;

	pbmc_port DUT (.ref_clk(ref_clk), .resetn(resetn), .axil_req(rq), .axil_rsp(rs), .poll(poll),
		.inhibit(inhibit), .ack(ack), .irq(irq), .frame_sync(frame_sync), .rx_bit(rx_bit), .tx_bit(tx_bit));
	pbmc_bus_model bus (.ref_clk(ref_clk), .resetn(resetn), .poll(poll), .inhibit(inhibit), .ack(ack),
		.frame_sync(frame_sync), .rx_bit(rx_bit), .tx_bit(tx_bit));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	initial begin
		#400000;
		mismatches++;
		close_out();
	end
	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	task automatic close_out();
		if (mismatches == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		rq.awvalid <= 1'b1;
		rq.wvalid <= 1'b1;
		rq.awaddr <= a;
		rq.wdata <= v;
		rq.wstrb <= 4'hf;
		rq.bready <= 1'b1;
		do @(posedge ref_clk); while (!(rs.awready === 1'b1 && rs.wready === 1'b1));
		rq.awvalid <= 1'b0;
		rq.wvalid <= 1'b0;
		while (rs.bvalid !== 1'b1) @(posedge ref_clk);
		r = rs.bresp;
		rq.bready <= 1'b0;
	endtask : wr
	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge ref_clk);
		rq.arvalid <= 1'b1;
		rq.araddr <= a;
		rq.rready <= 1'b1;
		do @(posedge ref_clk); while (rs.arready !== 1'b1);
		rq.arvalid <= 1'b0;
		while (rs.rvalid !== 1'b1) @(posedge ref_clk);
		d = rs.rdata;
		r = rs.rresp;
		rq.rready <= 1'b0;
		chk(nm, e, d & m);
	endtask : rdc
	task automatic at(input int n);
		do @(posedge ref_clk); while (int'(bus.pcnt) != n);
	endtask : at
	function automatic logic [7:0] crc8(input logic [175:0] v);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 175; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction : crc8
	// -------------------------------------------------------------
	// tests
	// -------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		rq = '0;
		mismatches = 0;
		n_tests = 0;
		bus.cw = '0;
		bus.blk = 64'hc3a50f96_1234abcd;
		bus.nbits = 64;
		bus.cw_go = 1'b0;
		bus.blk_go = 1'b0;
		bus.abort = 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		chk("lines", 32'h0, {29'h0, inhibit, ack, irq});
		rdc("control", OFS_CONTROL, 32'hffffffff, 32'h0);
		rdc("status", OFS_STATUS, 32'hff, 32'h0);
		wr(12'h020, 32'h1);
		chk("wr_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
		rdc("unmapped", 12'h200, 32'hffffffff, 32'h0);
		chk("rd_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(OFS_SEQ, 32'h89abcdef);
		rdc("seq_ro", OFS_SEQ, 32'hffffffff, 32'h0);
		wr(12'h108, 32'h5a5a1234);
		rdc("buf_wr", 12'h108, 32'hffffffff, 32'h5a5a1234);
		// good control word, interrupt request, received block
		body = {16'h0102, 8'h81, 8'h22, 8'h33, 32'h7, 32'h100, 32'h800, 40'h0};
		at(100);
		wr(OFS_CONTROL, 32'h9);
		chk("irq", 32'h1, {31'h0, irq});
		bus.cw <= {body, crc8(body)};
		bus.cw_go <= 1'b1;
		bus.blk_go <= 1'b1;
		at(740);
		bus.cw_go <= 1'b0;
		rdc("cw_ok", OFS_STATUS, 32'h6, 32'h2);
		rdc("func", OFS_FUNC, 32'hffff, 32'h0102);
		rdc("ident", OFS_IDENT, 32'hffffff, 32'h812233);
		rdc("start", OFS_START, 32'hffffffff, 32'h100);
		rdc("total", OFS_TOTAL, 32'hffffffff, 32'h800);
		rdc("seq_cw", OFS_SEQ, 32'hffffffff, 32'h7);
		at(1003);
		chk("irq_clr", 32'h0, {31'h0, irq});
		at(1500);
		bus.blk_go <= 1'b0;
		at(10);
		chk("ack_seen", 32'h1, {31'h0, bus.got_ack});
		chk("ack_low", 32'h0, {31'h0, ack});
		chk("no_fail", 32'h0, {31'h0, bus.fail});
		rdc("rx_status", OFS_STATUS, 32'hff, 32'h43);
		rdc("word0", 12'h100, 32'hffffffff, 32'hc3a50f96);
		rdc("word1", 12'h104, 32'hffffffff, 32'h1234abcd);
		rdc("count", OFS_COUNT, 32'hffffffff, 32'h40);
		wr(OFS_STATUS, 32'h1f);
		chk("inh_free", 32'h0, {31'h0, inhibit});
		wr(OFS_CONTROL, 32'h11);
		chk("inh_busy", 32'h1, {31'h0, inhibit});
		wr(OFS_CONTROL, 32'h1);
		// bad check code, poll dropped in mid data slot after the block bits
		bus.cw <= {body, crc8(body) ^ 8'h01};
		bus.cw_go <= 1'b1;
		bus.blk_go <= 1'b1;
		bus.abort <= 1'b1;
		at(740);
		bus.cw_go <= 1'b0;
		at(2100);
		bus.blk_go <= 1'b0;
		bus.abort <= 1'b0;
		at(10);
		rdc("bad_blk", OFS_STATUS, 32'h1f, 32'h0c);
		chk("no_ack", 32'h0, {31'h0, bus.got_ack});
		rdc("func_kept", OFS_FUNC, 32'hffff, 32'h0102);
		wr(OFS_STATUS, 32'h1f);
		// full block sent on class one
		wr(OFS_CONTROL, 32'h7);
		bus.nbits <= 0;
		bus.blk_go <= 1'b1;
		at(1100);
		n0 = bus.ntx;
		bus.blk_go <= 1'b0;
		at(10);
		chk("tx_bits", 32'(BLOCK_BITS), 32'(bus.ntx - n0));
		chk("tx_hi", 32'hc3a50f96, bus.txw[63:32]);
		chk("tx_lo", 32'h1234abcd, bus.txw[31:0]);
		rdc("tx_done", OFS_STATUS, 32'h10, 32'h10);
		close_out();
	end
endmodule : pbmc_port_tb
`default_nettype wire
